// File: design/sdo_defines.svh
`ifndef SDO_DEFINES_SVH
`define SDO_DEFINES_SVH
// abort codes
`define ABT_TOGGLE        32'h05030000
`define ABT_TIMEOUT       32'h05040000
`define ABT_BAD_CMD       32'h05040001
`define ABT_UNSUPPORTED   32'h06010000
`define ABT_READ_WO       32'h06010001
`define ABT_WRITE_RO      32'h06010002
`define ABT_NO_OBJECT     32'h06020000
`define ABT_NOT_MAPPABLE  32'h06040041
`define ABT_MAP_OVERFLOW  32'h06040042
`define ABT_HW_FAIL       32'h06060000
`define ABT_LEN_MISMATCH  32'h06070010
`define ABT_LEN_HIGH      32'h06070012
`define ABT_LEN_LOW       32'h06070013
`define ABT_NO_SUBINDEX   32'h06090011
`define ABT_RANGE         32'h06090030
`define ABT_VALUE_HIGH    32'h06090031
`define ABT_VALUE_LOW     32'h06090032
`define ABT_GENERAL       32'h08000000
`define ABT_XFER_FAIL     32'h08000020
`define ABT_LOCAL_CTRL    32'h08000021
`define ABT_DEV_STATE     32'h08000022
// object dictionary
`define IDX_DIAG_HISTORY  16'h10F3
`define IDX_ERROR_REG     16'h1001
`define SUB_NOTIFY_FLAGS  8'h05
`define SUB_DIAG_FIRST    8'h06
`define SUB_DIAG_LAST     8'h0D
`define SUB_ZERO          8'h00
`define NOTIFY_OFF        16'h0000
`define NOTIFY_ON         16'h0001
`define NOTIFY_RESET      16'h0000
`define DIAG_SLOTS        8
// timing
`define CLK_PERIOD_NS     8
`define SDO_TIMEOUT_US    1000
`define SDO_TIMEOUT_CYC   ((`SDO_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define DC_PERIOD_US      500
`define DC_PERIOD_CYC     ((`DC_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`endif

// File: design/sdo_pkg.sv
package sdo_pkg;
    typedef enum logic [2:0] {
        CMD_UPLOAD   = 3'h0,
        CMD_DOWNLOAD = 3'h1,
        CMD_SEGMENT  = 3'h2,
        CMD_AMP      = 3'h3,
        CMD_MAP      = 3'h4
    } cmd_type;

    typedef enum logic [2:0] {
        AMP_OK        = 3'h0,
        AMP_UNSUPP    = 3'h1,
        AMP_RANGE     = 3'h2,
        AMP_COMM_FAIL = 3'h3
    } amp_status_type;

    typedef enum logic [1:0] {
        MAP_OK       = 2'h0,
        MAP_BAD_OBJ  = 2'h1,
        MAP_OVERFLOW = 2'h2
    } map_status_type;
endpackage

// File: design/sdo_link_if.sv
`timescale 1ns/1ps
// mailbox link between fieldbus master and slave service logic
interface sdo_link_if;
    logic        req_valid;
    logic [2:0]  req_cmd;
    logic [15:0] req_index;
    logic [7:0]  req_sub;
    logic [2:0]  req_len;
    logic        req_toggle;
    logic [31:0] req_data;
    logic        rsp_valid;
    logic        rsp_abort;
    logic [31:0] rsp_code;
    logic [31:0] rsp_data;
    logic        emcy_valid;
    logic [63:0] emcy_msg;
    logic        dc_cycle_pulse;
    logic        shared_clock_mode_one;

    modport master (
        output req_valid, req_cmd, req_index, req_sub, req_len, req_toggle, req_data,
        output dc_cycle_pulse, shared_clock_mode_one,
        input  rsp_valid, rsp_abort, rsp_code, rsp_data, emcy_valid, emcy_msg
    );
    modport slave (
        input  req_valid, req_cmd, req_index, req_sub, req_len, req_toggle, req_data,
        input  dc_cycle_pulse, shared_clock_mode_one,
        output rsp_valid, rsp_abort, rsp_code, rsp_data, emcy_valid, emcy_msg
    );
endinterface

// File: design/sdo_slave.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
// Summary of operation
// - abort read-only write, missing index
// - missing sub-index aborts with its code
// - length mismatch: general, too long, too short
// - out-of-range write: range, above max, below min
// - unchanged segment toggle aborts transfer
// - abort on protocol timeout or bad command
// - reject unmappable object or mapping overflow
// - unsupported amplifier command aborts local-control code
// - amplifier parameter out of range aborts
// - amplifier failure aborts; master flags a retry
// - hardware fail, general error, state forbids storing
// - free-running mode uses own I/O timing
// - shared-clock mode runs I/O on cycle pulse
// - master sets pulse period 500us to 4ms
// - notify flag sub 05 of 10F3 gates messages
// - notify flag clears at power-on
// - no emergency message during link errors
// - emergency message: code, error register, reserved, status
// - eight history entries read at subs 06-0D
// - history fills from slot 0, wraps after 8
// - history recorded even when not notified
// - memory errors never enter the history
module sdo_slave #(
    parameter int unsigned TIMEOUT_CYC = `SDO_TIMEOUT_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    sdo_link_if.slave        link,
    input  wire logic        link_error,
    input  wire logic        hw_fail,
    input  wire logic        state_locked,
    input  wire logic        general_fail,
    input  wire logic [2:0]  amp_status,
    input  wire logic [1:0]  map_status,
    input  wire logic        err_valid,
    input  wire logic        err_is_nvm,
    input  wire logic [15:0] err_code,
    input  wire logic [7:0]  err_register,
    input  wire logic [31:0] err_status,
    input  wire logic [15:0] limit_max,
    input  wire logic [15:0] limit_min,
    input  wire logic [2:0]  nvm_wr_slot_in,
    input  wire logic        nvm_load,
    output logic             io_strobe,
    output logic [2:0]       nvm_wr_slot,
    output logic [15:0]      notify_flags
);
    // a watchdog shorter than the answer latency would abort every segment
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("timeout too short");
    end

    typedef struct packed {
        logic        rsp_valid;
        logic        rsp_abort;
        logic [31:0] rsp_code;
        logic [31:0] rsp_data;
        logic        emcy_valid;
        logic [63:0] emcy_msg;
        logic [15:0] notify;
        logic [2:0]  wr_ptr;
        logic [7:0][63:0] hist;
        logic        seg_active;
        logic        last_toggle;
        logic [31:0] timer;
        logic        io_strobe;
        logic        free_tick;
    } state_type;

    state_type st_q;
    state_type st_d;

    // decode one request into an abort code, zero when accepted
    function automatic logic [31:0] check_req(input state_type s, input logic [2:0] cmd,
                                              input logic [15:0] idx, input logic [7:0] sub,
                                              input logic [2:0] len, input logic tgl,
                                              input logic [31:0] data);
        logic [31:0] code;
        code = 32'h00000000;
        if (hw_fail) begin
            code = `ABT_HW_FAIL;
        end else if (general_fail) begin
            code = `ABT_GENERAL;
        end else if (cmd == sdo_pkg::CMD_AMP) begin
            if (amp_status == sdo_pkg::AMP_UNSUPP) code = `ABT_LOCAL_CTRL;
            else if (amp_status == sdo_pkg::AMP_RANGE) code = `ABT_RANGE;
            else if (amp_status == sdo_pkg::AMP_COMM_FAIL) code = `ABT_XFER_FAIL;
        end else if (cmd == sdo_pkg::CMD_MAP) begin
            if (map_status == sdo_pkg::MAP_BAD_OBJ) code = `ABT_NOT_MAPPABLE;
            else if (map_status == sdo_pkg::MAP_OVERFLOW) code = `ABT_MAP_OVERFLOW;
        end else if (cmd == sdo_pkg::CMD_SEGMENT) begin
            if (!s.seg_active) code = `ABT_BAD_CMD;
            else if (tgl == s.last_toggle) code = `ABT_TOGGLE;
        end else if (cmd != sdo_pkg::CMD_UPLOAD && cmd != sdo_pkg::CMD_DOWNLOAD) begin
            code = `ABT_BAD_CMD;
        end else if (idx == `IDX_ERROR_REG) begin
            if (sub != `SUB_ZERO) code = `ABT_NO_SUBINDEX;
            else if (cmd == sdo_pkg::CMD_DOWNLOAD) code = `ABT_WRITE_RO;
        end else if (idx != `IDX_DIAG_HISTORY) begin
            code = `ABT_NO_OBJECT;
        end else if (sub < `SUB_NOTIFY_FLAGS || sub > `SUB_DIAG_LAST) begin
            code = `ABT_NO_SUBINDEX;
        end else if (sub >= `SUB_DIAG_FIRST) begin
            if (cmd == sdo_pkg::CMD_DOWNLOAD) code = `ABT_WRITE_RO;
        end else if (cmd == sdo_pkg::CMD_DOWNLOAD) begin
            // notify flags: 2-byte object, exact length and 0/1 value
            if (state_locked) code = `ABT_DEV_STATE;
            else if (len == 3'd0) code = 32'h00000000; // segmented start, value follows
            else if (len > 3'd2) code = `ABT_LEN_HIGH;
            else if (len < 3'd2) code = `ABT_LEN_LOW;
            else if (data[31:16] != 16'h0000) code = `ABT_LEN_MISMATCH;
            else if (data[15:0] > limit_max) code = `ABT_VALUE_HIGH;
            else if (data[15:0] < limit_min) code = `ABT_VALUE_LOW;
            else if (data[15:0] > `NOTIFY_ON) code = `ABT_RANGE;
        end
        return code;
    endfunction

    always_comb begin
        logic [31:0] code;
        logic [2:0]  slot;
        code = 32'h00000000;
        slot = 3'h0;
        st_d = st_q;
        st_d.rsp_valid  = 1'b0;
        st_d.emcy_valid = 1'b0;
        st_d.io_strobe  = 1'b0;
        st_d.free_tick  = ~st_q.free_tick;
        // i/o processing pace depends on sync mode
        if (link.shared_clock_mode_one) begin
            st_d.io_strobe = link.dc_cycle_pulse;
        end else begin
            st_d.io_strobe = st_q.free_tick;
        end
        // pointer restored from non-volatile copy on load, except when an error is captured in the same cycle
        if (nvm_load) st_d.wr_ptr = nvm_wr_slot_in;
        // segmented transfer watchdog
        if (st_q.seg_active) st_d.timer = st_q.timer + 32'd1;
        if (link.req_valid) begin
            code = check_req(st_q, link.req_cmd, link.req_index, link.req_sub,
                             link.req_len, link.req_toggle, link.req_data);
            st_d.rsp_valid = 1'b1;
            st_d.rsp_abort = (code != 32'h00000000);
            st_d.rsp_code  = code;
            st_d.rsp_data  = 32'h00000000;
            st_d.timer     = 32'h00000000;
            if (code != 32'h00000000) begin
                st_d.seg_active = 1'b0;
            end else if (link.req_cmd == sdo_pkg::CMD_SEGMENT) begin
                st_d.last_toggle = link.req_toggle;
            end else if (link.req_cmd == sdo_pkg::CMD_UPLOAD) begin
                if (link.req_index == `IDX_ERROR_REG) begin
                    st_d.rsp_data = {24'h000000, err_register};
                end else if (link.req_sub == `SUB_NOTIFY_FLAGS) begin
                    st_d.rsp_data = {16'h0000, st_q.notify};
                end else begin
                    slot = 3'(link.req_sub - `SUB_DIAG_FIRST);
                    st_d.rsp_data = st_q.hist[slot][31:0];
                end
            end else if (link.req_cmd == sdo_pkg::CMD_DOWNLOAD) begin
                // a segmented start carries no value, so the flag stays as it is
                if (link.req_len != 3'd0) st_d.notify = link.req_data[15:0];
                st_d.seg_active  = (link.req_len == 3'd0);
                st_d.last_toggle = 1'b1;
            end
        end else if (st_q.seg_active && st_q.timer >= TIMEOUT_CYC - 1) begin
            st_d.rsp_valid  = 1'b1;
            st_d.rsp_abort  = 1'b1;
            st_d.rsp_code   = `ABT_TIMEOUT;
            st_d.seg_active = 1'b0;
        end
        // error capture: history always, message only when allowed
        if (err_valid && !err_is_nvm) begin
            st_d.emcy_msg = {err_status, 8'h00, err_register, err_code};
            st_d.hist[st_q.wr_ptr] = {err_status, 8'h00, err_register, err_code};
            st_d.wr_ptr = st_q.wr_ptr + 3'd1;
            st_d.emcy_valid = (st_q.notify == `NOTIFY_ON) && !link_error;
        end
    end

    // power-on clears notify flag, pointer starts at slot 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.notify <= `NOTIFY_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.rsp_valid  = st_q.rsp_valid;
    assign link.rsp_abort  = st_q.rsp_abort;
    assign link.rsp_code   = st_q.rsp_code;
    assign link.rsp_data   = st_q.rsp_data;
    assign link.emcy_valid = st_q.emcy_valid;
    assign link.emcy_msg   = st_q.emcy_msg;
    assign io_strobe       = st_q.io_strobe;
    assign nvm_wr_slot     = st_q.wr_ptr;
    assign notify_flags    = st_q.notify;
endmodule

// File: design/sdo_master.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
// master end: forwards one user request, paces the cycle pulse
module sdo_master #(
    parameter int unsigned PERIOD_CYC = `DC_PERIOD_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    sdo_link_if.master       link,
    input  wire logic        user_valid,
    input  wire logic [2:0]  user_cmd,
    input  wire logic [15:0] user_index,
    input  wire logic [7:0]  user_sub,
    input  wire logic [2:0]  user_len,
    input  wire logic [31:0] user_data,
    input  wire logic        user_dc_mode,
    input  wire logic [1:0]  user_period_sel,
    output logic             user_ready,
    output logic             user_done,
    output logic             user_abort,
    output logic [31:0]      user_code,
    output logic [31:0]      user_rdata,
    output logic             user_retry
);
    // the counter needs at least two states to make a one-cycle pulse
    if (PERIOD_CYC < 2) begin : g_bad_period
        $error("period too short");
    end

    typedef struct packed {
        logic        busy;
        logic        req_valid;
        logic [2:0]  cmd;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [2:0]  len;
        logic [31:0] data;
        logic        toggle;
        logic        done;
        logic        abort;
        logic [31:0] code;
        logic [31:0] rdata;
        logic        retry;
        logic [31:0] cnt;
        logic        pulse;
    } state_type;

    state_type st_q;
    state_type st_d;

    // pulse period is 500us times 1,2,4,8
    always_comb begin
        st_d = st_q;
        st_d.req_valid = 1'b0;
        st_d.done  = 1'b0;
        st_d.pulse = 1'b0;
        st_d.retry = 1'b0;
        if (st_q.cnt >= ((PERIOD_CYC << user_period_sel) - 1)) begin
            st_d.cnt   = 32'h00000000;
            st_d.pulse = user_dc_mode;
        end else begin
            st_d.cnt = st_q.cnt + 32'd1;
        end
        if (!st_q.busy && user_valid) begin
            st_d.busy = 1'b1;
            st_d.req_valid = 1'b1;
            st_d.cmd = user_cmd;
            st_d.index = user_index;
            st_d.sub = user_sub;
            st_d.len = user_len;
            st_d.data = user_data;
            if (user_cmd == sdo_pkg::CMD_SEGMENT) st_d.toggle = ~st_q.toggle;
            else st_d.toggle = 1'b1;
        end
        if (st_q.busy && link.rsp_valid) begin
            st_d.busy  = 1'b0;
            st_d.done  = 1'b1;
            st_d.abort = link.rsp_abort;
            st_d.code  = link.rsp_code;
            st_d.rdata = link.rsp_data;
            st_d.retry = link.rsp_abort && link.rsp_code == `ABT_XFER_FAIL;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.req_valid  = st_q.req_valid;
    assign link.req_cmd    = st_q.cmd;
    assign link.req_index  = st_q.index;
    assign link.req_sub    = st_q.sub;
    assign link.req_len    = st_q.len;
    assign link.req_toggle = st_q.toggle;
    assign link.req_data   = st_q.data;
    assign link.dc_cycle_pulse        = st_q.pulse;
    assign link.shared_clock_mode_one = user_dc_mode;
    assign user_ready = !st_q.busy;
    assign user_done  = st_q.done;
    assign user_abort = st_q.abort;
    assign user_code  = st_q.code;
    assign user_rdata = st_q.rdata;
    assign user_retry = st_q.retry;
endmodule

// File: testbench/sdo_abort_emergency_diag_properties.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
// watches the mailbox link where both ends are design modules
module sdo_abort_emergency_diag_properties (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        req_valid,
    input wire logic [2:0]  req_cmd,
    input wire logic [15:0] req_index,
    input wire logic [7:0]  req_sub,
    input wire logic [2:0]  req_len,
    input wire logic        req_toggle,
    input wire logic        rsp_valid,
    input wire logic        rsp_abort,
    input wire logic [31:0] rsp_code,
    input wire logic        emcy_valid,
    input wire logic [63:0] emcy_msg,
    input wire logic        dc_cycle_pulse
);
    logic hi_prio;
    // hardware and general faults outrank every other abort code
    assign hi_prio = rsp_code == `ABT_HW_FAIL || rsp_code == `ABT_GENERAL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // toggle of the last accepted segment; any abort or new download ends the transfer
    logic seg_pend_q, pend_tgl_q, seg_seen_q, seg_tgl_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seg_pend_q <= 1'b0;
            pend_tgl_q <= 1'b0;
            seg_seen_q <= 1'b0;
            seg_tgl_q  <= 1'b0;
        end else begin
            seg_pend_q <= req_valid && req_cmd == sdo_pkg::CMD_SEGMENT;
            pend_tgl_q <= req_toggle;
            if (rsp_valid && rsp_abort) begin
                seg_seen_q <= 1'b0;
            end else if (seg_pend_q && rsp_valid) begin
                seg_seen_q <= 1'b1;
                seg_tgl_q  <= pend_tgl_q;
            end else if (req_valid && req_cmd == sdo_pkg::CMD_DOWNLOAD) begin
                seg_seen_q <= 1'b0;
            end
        end
    end
    sequence seg_repeat;
        req_valid && req_cmd == sdo_pkg::CMD_SEGMENT && seg_seen_q && req_toggle == seg_tgl_q;
    endsequence
    sequence toggle_refused;
        rsp_abort && (rsp_code == `ABT_TOGGLE || hi_prio);
    endsequence
    AST_ANSWER: assert property (req_valid |=> rsp_valid ##1 !rsp_valid)
        else $error("answer not one cycle after request");
    AST_NO_SUB: assert property (req_valid && req_cmd == sdo_pkg::CMD_UPLOAD
        && req_index == `IDX_DIAG_HISTORY && req_sub > `SUB_DIAG_LAST
        |=> rsp_abort && (rsp_code == `ABT_NO_SUBINDEX || hi_prio))
        else $error("missing sub-index not refused");
    AST_BAD_CMD: assert property (req_valid && req_cmd > 3'h4
        |=> rsp_abort && (rsp_code == `ABT_BAD_CMD || hi_prio))
        else $error("unknown command not refused");
    AST_WRITE_RO: assert property (req_valid && req_cmd == sdo_pkg::CMD_DOWNLOAD
        && req_index == `IDX_ERROR_REG && req_sub == `SUB_ZERO
        |=> rsp_code == `ABT_WRITE_RO || hi_prio)
        else $error("read-only write not refused");
    AST_LEN_HIGH: assert property (req_valid && req_cmd == sdo_pkg::CMD_DOWNLOAD
        && req_index == `IDX_DIAG_HISTORY && req_sub == `SUB_NOTIFY_FLAGS && req_len > 3'h2
        |=> rsp_code == `ABT_LEN_HIGH || rsp_code == `ABT_DEV_STATE || hi_prio)
        else $error("long write not refused");
    AST_TOGGLE: assert property (seg_repeat |=> toggle_refused)
        else $error("repeated toggle not refused");
    AST_UNSOLICITED: assert property (rsp_valid |-> $past(req_valid) || rsp_code == `ABT_TIMEOUT)
        else $error("answer without request");
    AST_EMCY_ONE: assert property (emcy_valid |=> !emcy_valid)
        else $error("emergency strobe longer than one cycle");
    AST_EMCY_RSV: assert property (emcy_valid |-> emcy_msg[31:24] == 8'h00)
        else $error("emergency reserved byte not zero");
    // period of 8 cycles is the shortest setting used on the bench
    AST_DC_GAP: assert property (dc_cycle_pulse |=> !dc_cycle_pulse [*7])
        else $error("cycle pulses too close");
endmodule

// File: testbench/sdo_abort_emergency_diag_tb.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
module sdo_abort_emergency_diag_tb;
    logic        clk, arst_n, uv, dcm, lerr, hwf, stl, gf, ev, env, ld, ur, ud, ua, rty, io;
    logic [2:0]  uc, ul, amp, slot_in, slot;
    logic [15:0] ui, ec, nf, lmax, lmin;
    logic [7:0]  us, er;
    logic [31:0] ud32, es, ucode, rd;
    logic [1:0]  mp, ps;
    logic [63:0] msg;
    int          errors, cmp_count, k, n;
    logic [31:0] ac[4] = '{32'h0, `ABT_LOCAL_CTRL, `ABT_RANGE, `ABT_XFER_FAIL};
    sdo_link_if sdo_link_if_i ();
    sdo_master #(.PERIOD_CYC(8)) sdo_master_i (.clk(clk), .arst_n(arst_n),
        .link(sdo_link_if_i.master), .user_valid(uv), .user_cmd(uc), .user_index(ui),
        .user_sub(us), .user_len(ul), .user_data(ud32), .user_dc_mode(dcm),
        .user_period_sel(ps), .user_ready(ur), .user_done(ud), .user_abort(ua),
        .user_code(ucode), .user_rdata(rd), .user_retry(rty));
    sdo_slave #(.TIMEOUT_CYC(16)) sdo_slave_i (.clk(clk), .arst_n(arst_n),
        .link(sdo_link_if_i.slave), .link_error(lerr), .hw_fail(hwf), .state_locked(stl),
        .general_fail(gf), .amp_status(amp), .map_status(mp), .err_valid(ev),
        .err_is_nvm(env), .err_code(ec), .err_register(er), .err_status(es),
        .limit_max(lmax), .limit_min(lmin), .nvm_wr_slot_in(slot_in),
        .nvm_load(ld), .io_strobe(io), .nvm_wr_slot(slot), .notify_flags(nf));
    sdo_abort_emergency_diag_properties sdo_abort_emergency_diag_properties_i (
        .clk(clk), .arst_n(arst_n), .req_valid(sdo_link_if_i.req_valid),
        .req_cmd(sdo_link_if_i.req_cmd), .req_index(sdo_link_if_i.req_index),
        .req_sub(sdo_link_if_i.req_sub), .req_len(sdo_link_if_i.req_len),
        .req_toggle(sdo_link_if_i.req_toggle), .rsp_valid(sdo_link_if_i.rsp_valid),
        .rsp_abort(sdo_link_if_i.rsp_abort), .rsp_code(sdo_link_if_i.rsp_code),
        .emcy_valid(sdo_link_if_i.emcy_valid), .emcy_msg(sdo_link_if_i.emcy_msg),
        .dc_cycle_pulse(sdo_link_if_i.dc_cycle_pulse));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task summarize;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // one user request through the master end, bounded waits on both sides
    task xc(input logic [2:0] c, input logic [15:0] ix, input logic [7:0] sb,
            input logic [2:0] ln, input logic [31:0] d, input logic [31:0] e);
        k = 0;
        while (ur !== 1'b1 && k < 50) begin step(1); k++; end
        if (ur !== 1'b1) begin errors++; summarize(); end
        uv = 1'b1; uc = c; ui = ix; us = sb; ul = ln; ud32 = d;
        step(1);
        uv = 1'b0;
        k = 0;
        while (ud !== 1'b1 && k < 50) begin step(1); k++; end
        if (ud !== 1'b1) begin errors++; summarize(); end
        chk("code", e, ucode);
        chk("abort", {31'h0, e != 32'h0}, {31'h0, ua});
    endtask
    // one error event; an idle edge follows so strobes never merge
    task errp(input logic nv, input logic [15:0] c);
        ev = 1'b1; env = nv; ec = c;
        step(1);
        ev = 1'b0; n = 0;
        msg = 64'h0;
        repeat (4) begin
            if (sdo_link_if_i.emcy_valid === 1'b1) begin n++; msg = sdo_link_if_i.emcy_msg; end
            step(1);
        end
    endtask
    task reset;
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
    endtask
    initial begin
        {uv, dcm, lerr, hwf, stl, gf, ev, env, ld} = '0;
        {uc, ul, amp, slot_in, ui, ec, us, ud32, mp, ps} = '0;
        er = 8'h5A; es = 32'hCAFE0001; errors = 0; cmp_count = 0;
        lmax = 16'hFFFF;
        lmin = 16'h0000;
        reset();
        chk("notify", `NOTIFY_RESET, {16'h0, nf});
        chk("slot", 32'h0, {29'h0, slot});
        xc(sdo_pkg::CMD_UPLOAD, `IDX_DIAG_HISTORY, 8'h20, 3'h4, 32'h0, `ABT_NO_SUBINDEX);
        xc(sdo_pkg::CMD_UPLOAD, 16'h2345, 8'h00, 3'h4, 32'h0, `ABT_NO_OBJECT);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_ERROR_REG, 8'h00, 3'h1, 32'h0, `ABT_WRITE_RO);
        xc(3'h7, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h0, `ABT_BAD_CMD);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h4, 32'h1, `ABT_LEN_HIGH);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h1, 32'h1, `ABT_LEN_LOW);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h2, `ABT_RANGE);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h10001,
           `ABT_LEN_MISMATCH);
        lmax = 16'h0000;
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, `ABT_VALUE_HIGH);
        lmax = 16'hFFFF;
        lmin = 16'h0001;
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h0, `ABT_VALUE_LOW);
        lmin = 16'h0000;
        chk("notify", `NOTIFY_OFF, {16'h0, nf});
        for (int i = 1; i < 4; i++) begin
            amp = i[2:0];
            xc(sdo_pkg::CMD_AMP, 16'h4001, 8'h01, 3'h2, 32'h0, ac[i]);
            chk("retry", {31'h0, i == 3}, {31'h0, rty});
        end
        amp = 3'h0;
        xc(sdo_pkg::CMD_AMP, 16'h4001, 8'h01, 3'h2, 32'h0, 32'h0);
        mp = 2'h1;
        xc(sdo_pkg::CMD_MAP, 16'h1A00, 8'h01, 3'h4, 32'h0, `ABT_NOT_MAPPABLE);
        mp = 2'h2;
        xc(sdo_pkg::CMD_MAP, 16'h1A00, 8'h01, 3'h4, 32'h0, `ABT_MAP_OVERFLOW);
        mp = 2'h0; hwf = 1'b1;
        xc(sdo_pkg::CMD_UPLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h0, `ABT_HW_FAIL);
        hwf = 1'b0; gf = 1'b1;
        xc(sdo_pkg::CMD_UPLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h0, `ABT_GENERAL);
        gf = 1'b0; stl = 1'b1;
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, `ABT_DEV_STATE);
        stl = 1'b0;
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, 32'h0);
        chk("notify", `NOTIFY_ON, {16'h0, nf});
        $display("object access test done");
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h0, 32'h0, 32'h0);
        xc(sdo_pkg::CMD_SEGMENT, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, 32'h0);
        // any other command restarts the master's toggle, so the next segment repeats it
        xc(sdo_pkg::CMD_AMP, 16'h4001, 8'h01, 3'h2, 32'h0, 32'h0);
        xc(sdo_pkg::CMD_SEGMENT, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, `ABT_TOGGLE);
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h0, 32'h0, 32'h0);
        k = 0;
        while (sdo_link_if_i.rsp_valid !== 1'b1 && k < 40) begin step(1); k++; end
        chk("timeout", `ABT_TIMEOUT, sdo_link_if_i.rsp_code);
        $display("segment test done");
        errp(1'b0, 16'h1234);
        chk("emcy count", 32'h1, n);
        chk("emcy low", {8'h00, er, 16'h1234}, msg[31:0]);
        chk("emcy status", es, msg[63:32]);
        chk("slot", 32'h1, {29'h0, slot});
        lerr = 1'b1;
        errp(1'b0, 16'h2000);
        chk("emcy count", 32'h0, n);
        chk("slot", 32'h2, {29'h0, slot});
        errp(1'b1, 16'h3000);
        chk("slot", 32'h2, {29'h0, slot});
        lerr = 1'b0;
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h0, 32'h0);
        for (int i = 0; i < 6; i++) errp(1'b0, 16'h2100);
        chk("emcy count", 32'h0, n);
        chk("slot", 32'h0, {29'h0, slot});
        xc(sdo_pkg::CMD_UPLOAD, `IDX_DIAG_HISTORY, `SUB_DIAG_FIRST, 3'h4, 32'h0, 32'h0);
        chk("history", {8'h00, er, 16'h1234}, rd);
        errp(1'b0, 16'h2200);
        xc(sdo_pkg::CMD_UPLOAD, `IDX_DIAG_HISTORY, `SUB_DIAG_FIRST, 3'h4, 32'h0, 32'h0);
        chk("history", {8'h00, er, 16'h2200}, rd);
        slot_in = 3'h5; ld = 1'b1;
        step(1);
        ld = 1'b0;
        step(1);
        chk("slot", 32'h5, {29'h0, slot});
        $display("history test done");
        step(4);
        n = 0;
        repeat (32) begin if (io === 1'b1) n++; step(1); end
        chk("free strobes", 32'd16, n);
        dcm = 1'b1;
        for (int s = 0; s < 4; s++) begin
            ps = s[1:0];
            step(80);
            k = 0;
            while (sdo_link_if_i.dc_cycle_pulse !== 1'b1 && k < 80) begin step(1); k++; end
            k = 0; n = 0;
            step(1);
            while (sdo_link_if_i.dc_cycle_pulse !== 1'b1 && k < 80) begin
                if (io === 1'b1) n++;
                step(1); k++;
            end
            chk("period", 32'd8 << s, k + 1);
            chk("dc strobes", 32'h1, n + (io === 1'b1));
        end
        chk("mode", 32'h1, {31'h0, sdo_link_if_i.shared_clock_mode_one});
        $display("sync test done");
        xc(sdo_pkg::CMD_DOWNLOAD, `IDX_DIAG_HISTORY, 8'h05, 3'h2, 32'h1, 32'h0);
        reset();
        chk("notify", `NOTIFY_RESET, {16'h0, nf});
        $display("power cycle test done");
        summarize();
    end
endmodule
